/* include/pcdo_pkg.sv */
// Notes on behaviour
// [R01] Port C bit 1 carries the timer 1 compare B output as its value; its direction bit stays in charge.
// [R02] On Port C bits 3, 2 and 0 an active power stage output enable forces output and drives its value.
// [R03] On Port C bit 7 the DAC enable forces the pin to input and switches the digital input off.
// [R04] While the USART receiver is enabled, Port D bit 4 is forced to input whatever its direction bit.
// [R05] With Port D bit 4 forced to input by the receiver, a one in its port value bit turns the pull-up on.
// [R06] SPI slave forces the alternate clock pin (Port D bit 4) to input; as master the direction bit rules.
// [R07] While the USART transmitter is enabled, Port D bit 3 is forced to output and drives transmit data.
// [R08] Port D bit 3 carries the timer 0 compare A output only while its direction bit is set.
// [R09] SPI slave forces slave select on Port D bit 3 to input, the outside master drives it low.
// [R10] SPI slave forces the alternate master-out/slave-in pin (Port D bit 3) to input, pull-up kept.
// [R11] Port D bit 2 carries the timer 1 compare A output only while its direction bit is set.
// [R12] SPI master forces the alternate master-in/slave-out pin (Port D bit 2) to input, pull-up kept.
// [R13] With the clock-output fuse programmed, Port D bit 1 drives the divided clock regardless of port bits.
// [R14] With the clock-output fuse programmed, the divided clock stays on Port D bit 1 during reset.
// [R15] Software should leave comparator input pins on Port D as inputs with the pull-up off.
// [R16] Each pin attribute takes the override value while its override enable is set, else the port setting; input enable otherwise stays on.
`default_nettype none

package pcdo_pkg;

  // ----------------------------------------------------------------
  // pin positions
  // ----------------------------------------------------------------
  localparam int unsigned PC_STAGE1_OUT0_BIT = 0;
  localparam int unsigned PC_TIMER1_CMPB_BIT = 1;
  localparam int unsigned PC_STAGE2_OUT2_BIT = 2;
  localparam int unsigned PC_STAGE2_OUT3_BIT = 3;
  localparam int unsigned PC_DAC_BIT = 7;
  localparam int unsigned PD_CLOCK_OUT_BIT = 1;
  localparam int unsigned PD_MISO_ALT_BIT = 2;
  localparam int unsigned PD_TXD_MOSI_BIT = 3;
  localparam int unsigned PD_RXD_SCK_BIT = 4;

  // ----------------------------------------------------------------
  // reset values of the registered pin drive
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PIN_OUT = 8'h00;
  localparam logic [7:0] RST_PIN_OE_N = 8'hff;
  localparam logic [7:0] RST_PIN_PULL_UP = 8'h00;
  localparam logic [7:0] RST_PIN_IN_EN = 8'hff;
  localparam logic [7:0] RST_PIN_READ = 8'h00;

  // software port registers of one 8-bit port
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] dir;
  } pcdo_port_regs_t;

  // override controls of one pin
  typedef struct packed {
    logic direction_override_enable;
    logic direction_override_value;
    logic port_value_override_enable;
    logic port_value_override_value;
    logic pull_up_override_enable;
    logic pull_up_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pcdo_ovr_t;

  // resolved drive of one pin
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
    logic in_en;
  } pcdo_pin_t;

  // resolved drive of one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull_up;
    logic [7:0] in_en;
  } pcdo_port_drive_t;

endpackage

`default_nettype wire

/* logic/pcdo_pin_override.sv */
`default_nettype none

module pcdo_pin_override (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire pcdo_pkg::pcdo_port_regs_t portc_regs_i,
  input wire pcdo_pkg::pcdo_port_regs_t portd_regs_i,
  input wire logic pull_up_disable_i,
  input wire logic [7:0] portc_pin_i,
  input wire logic [7:0] portd_pin_i,
  input wire logic stage2_out3_enable_i,
  input wire logic stage2_out3_value_i,
  input wire logic stage2_out2_enable_i,
  input wire logic stage2_out2_value_i,
  input wire logic stage1_out0_enable_i,
  input wire logic stage1_out0_value_i,
  input wire logic timer1_cmpb_out_enable_i,
  input wire logic timer1_cmpb_output_i,
  input wire logic timer1_cmpa_out_enable_i,
  input wire logic timer1_cmpa_output_i,
  input wire logic timer0_cmpa_out_enable_i,
  input wire logic timer0_cmpa_output_i,
  input wire logic dac_enable_i,
  input wire logic ext_int3_enable_i,
  input wire logic usart_rx_enable_i,
  input wire logic usart_tx_enable_i,
  input wire logic usart_txd_i,
  input wire logic spi_enable_i,
  input wire logic spi_master_i,
  input wire logic spi_alt_pins_i,
  input wire logic spi_sck_out_i,
  input wire logic spi_mosi_out_i,
  input wire logic spi_miso_out_i,
  input wire logic clock_output_fuse_i,
  input wire logic divided_clock_i,
  output pcdo_pkg::pcdo_port_drive_t portc_drive_o,
  output pcdo_pkg::pcdo_port_drive_t portd_drive_o,
  output logic [7:0] portc_read_o,
  output logic [7:0] portd_read_o
);

  // ----------------------------------------------------------------
  // shared resolution of one pin
  // ----------------------------------------------------------------
  function automatic pcdo_pkg::pcdo_pin_t resolve_pin(
    input pcdo_pkg::pcdo_ovr_t ovr,
    input logic dir,
    input logic value,
    input logic pud
  );
    pcdo_pkg::pcdo_pin_t pin;
    logic dir_eff;
    dir_eff = ovr.direction_override_enable ? ovr.direction_override_value : dir; // R16
    pin.oe_n = ~dir_eff;
    pin.out = ovr.port_value_override_enable ? ovr.port_value_override_value : value; // R16
    pin.pull_up = ovr.pull_up_override_enable ? ovr.pull_up_override_value
                                              : (value & ~dir & ~pud); // R16
    pin.in_en = ovr.input_enable_override_enable ? ovr.input_enable_override_value
                                                 : 1'b1; // R16
    return pin;
  endfunction

  // ----------------------------------------------------------------
  // peripheral override terms
  // ----------------------------------------------------------------
  logic spi_alt_on;
  logic spi_alt_slave;
  logic spi_alt_master;
  pcdo_pkg::pcdo_ovr_t [7:0] portc_ovr;
  pcdo_pkg::pcdo_ovr_t [7:0] portd_ovr;

  assign spi_alt_on = spi_enable_i & spi_alt_pins_i;
  assign spi_alt_slave = spi_alt_on & ~spi_master_i;
  assign spi_alt_master = spi_alt_on & spi_master_i;

  always_comb begin
    portc_ovr = '0;
    portd_ovr = '0;
    // port c: power stage outputs take direction and value
    portc_ovr[pcdo_pkg::PC_STAGE2_OUT3_BIT].direction_override_enable = stage2_out3_enable_i; // R02
    portc_ovr[pcdo_pkg::PC_STAGE2_OUT3_BIT].direction_override_value = 1'b1; // R02
    portc_ovr[pcdo_pkg::PC_STAGE2_OUT3_BIT].port_value_override_enable = stage2_out3_enable_i; // R02
    portc_ovr[pcdo_pkg::PC_STAGE2_OUT3_BIT].port_value_override_value = stage2_out3_value_i; // R02
    portc_ovr[pcdo_pkg::PC_STAGE2_OUT2_BIT].direction_override_enable = stage2_out2_enable_i; // R02
    portc_ovr[pcdo_pkg::PC_STAGE2_OUT2_BIT].direction_override_value = 1'b1; // R02
    portc_ovr[pcdo_pkg::PC_STAGE2_OUT2_BIT].port_value_override_enable = stage2_out2_enable_i; // R02
    portc_ovr[pcdo_pkg::PC_STAGE2_OUT2_BIT].port_value_override_value = stage2_out2_value_i; // R02
    portc_ovr[pcdo_pkg::PC_STAGE1_OUT0_BIT].direction_override_enable = stage1_out0_enable_i; // R02
    portc_ovr[pcdo_pkg::PC_STAGE1_OUT0_BIT].direction_override_value = 1'b1; // R02
    portc_ovr[pcdo_pkg::PC_STAGE1_OUT0_BIT].port_value_override_enable = stage1_out0_enable_i; // R02
    portc_ovr[pcdo_pkg::PC_STAGE1_OUT0_BIT].port_value_override_value = stage1_out0_value_i; // R02
    portc_ovr[pcdo_pkg::PC_STAGE1_OUT0_BIT].input_enable_override_enable = ext_int3_enable_i;
    portc_ovr[pcdo_pkg::PC_STAGE1_OUT0_BIT].input_enable_override_value = ext_int3_enable_i;
    // compare b overrides the value only, so the pin is silent until software sets direction
    portc_ovr[pcdo_pkg::PC_TIMER1_CMPB_BIT].port_value_override_enable = timer1_cmpb_out_enable_i; // R01
    portc_ovr[pcdo_pkg::PC_TIMER1_CMPB_BIT].port_value_override_value = timer1_cmpb_output_i; // R01
    // dac owns the pin as an analog output; digital input cut to stop crowbar current
    portc_ovr[pcdo_pkg::PC_DAC_BIT].direction_override_enable = dac_enable_i; // R03
    portc_ovr[pcdo_pkg::PC_DAC_BIT].direction_override_value = 1'b0; // R03
    portc_ovr[pcdo_pkg::PC_DAC_BIT].input_enable_override_enable = dac_enable_i; // R03
    portc_ovr[pcdo_pkg::PC_DAC_BIT].input_enable_override_value = 1'b0; // R03

    // port d bit 4: receive data and alternate spi clock
    portd_ovr[pcdo_pkg::PD_RXD_SCK_BIT].direction_override_enable =
      usart_rx_enable_i | spi_alt_slave; // R04 R06
    portd_ovr[pcdo_pkg::PD_RXD_SCK_BIT].direction_override_value = 1'b0; // R04 R06
    portd_ovr[pcdo_pkg::PD_RXD_SCK_BIT].port_value_override_enable = spi_alt_master; // R06
    portd_ovr[pcdo_pkg::PD_RXD_SCK_BIT].port_value_override_value = spi_sck_out_i; // R06
    portd_ovr[pcdo_pkg::PD_RXD_SCK_BIT].pull_up_override_enable =
      usart_rx_enable_i | spi_alt_slave; // R05 R06
    portd_ovr[pcdo_pkg::PD_RXD_SCK_BIT].pull_up_override_value =
      portd_regs_i.value[pcdo_pkg::PD_RXD_SCK_BIT] & ~pull_up_disable_i; // R05 R06

    // port d bit 3: transmit wins over compare a, which wins over spi data
    portd_ovr[pcdo_pkg::PD_TXD_MOSI_BIT].direction_override_enable =
      usart_tx_enable_i | spi_alt_slave; // R07 R09 R10
    portd_ovr[pcdo_pkg::PD_TXD_MOSI_BIT].direction_override_value = usart_tx_enable_i; // R07 R09
    portd_ovr[pcdo_pkg::PD_TXD_MOSI_BIT].port_value_override_enable =
      usart_tx_enable_i | timer0_cmpa_out_enable_i | spi_alt_master; // R07 R08 R10
    portd_ovr[pcdo_pkg::PD_TXD_MOSI_BIT].port_value_override_value =
      usart_tx_enable_i ? usart_txd_i :
      (timer0_cmpa_out_enable_i ? timer0_cmpa_output_i : spi_mosi_out_i); // R07 R08
    portd_ovr[pcdo_pkg::PD_TXD_MOSI_BIT].pull_up_override_enable =
      usart_tx_enable_i | spi_alt_slave; // R10
    portd_ovr[pcdo_pkg::PD_TXD_MOSI_BIT].pull_up_override_value =
      ~usart_tx_enable_i & portd_regs_i.value[pcdo_pkg::PD_TXD_MOSI_BIT] &
      ~pull_up_disable_i; // R09 R10

    // port d bit 2: compare a, alternate spi master-in
    portd_ovr[pcdo_pkg::PD_MISO_ALT_BIT].direction_override_enable = spi_alt_master; // R12
    portd_ovr[pcdo_pkg::PD_MISO_ALT_BIT].direction_override_value = 1'b0; // R12
    portd_ovr[pcdo_pkg::PD_MISO_ALT_BIT].port_value_override_enable =
      timer1_cmpa_out_enable_i | spi_alt_slave; // R11
    portd_ovr[pcdo_pkg::PD_MISO_ALT_BIT].port_value_override_value =
      timer1_cmpa_out_enable_i ? timer1_cmpa_output_i : spi_miso_out_i; // R11
    portd_ovr[pcdo_pkg::PD_MISO_ALT_BIT].pull_up_override_enable = spi_alt_master; // R12
    portd_ovr[pcdo_pkg::PD_MISO_ALT_BIT].pull_up_override_value =
      portd_regs_i.value[pcdo_pkg::PD_MISO_ALT_BIT] & ~pull_up_disable_i; // R12

    // port d bit 1: divided clock, value itself bypasses the registers below
    portd_ovr[pcdo_pkg::PD_CLOCK_OUT_BIT].direction_override_enable = clock_output_fuse_i; // R13
    portd_ovr[pcdo_pkg::PD_CLOCK_OUT_BIT].direction_override_value = 1'b1; // R13
    portd_ovr[pcdo_pkg::PD_CLOCK_OUT_BIT].port_value_override_enable = clock_output_fuse_i; // R13
    portd_ovr[pcdo_pkg::PD_CLOCK_OUT_BIT].port_value_override_value = divided_clock_i; // R13
  end

  // ----------------------------------------------------------------
  // per pin resolution
  // ----------------------------------------------------------------
  pcdo_pkg::pcdo_port_drive_t portc_drive_d;
  pcdo_pkg::pcdo_port_drive_t portd_drive_d;
  pcdo_pkg::pcdo_port_drive_t portc_drive_q;
  pcdo_pkg::pcdo_port_drive_t portd_drive_q;
  logic [7:0] portc_read_d;
  logic [7:0] portd_read_d;
  logic [7:0] portc_read_q;
  logic [7:0] portd_read_q;

  for (genvar b = 0; b < 8; b++) begin : g_pin
    pcdo_pkg::pcdo_pin_t pc_pin;
    pcdo_pkg::pcdo_pin_t pd_pin;
    assign pc_pin = resolve_pin(portc_ovr[b], portc_regs_i.dir[b], portc_regs_i.value[b],
                                pull_up_disable_i);
    assign pd_pin = resolve_pin(portd_ovr[b], portd_regs_i.dir[b], portd_regs_i.value[b],
                                pull_up_disable_i);
    assign portc_drive_d.out[b] = pc_pin.out;
    assign portc_drive_d.oe_n[b] = pc_pin.oe_n;
    assign portc_drive_d.pull_up[b] = pc_pin.pull_up;
    assign portc_drive_d.in_en[b] = pc_pin.in_en;
    assign portd_drive_d.out[b] = pd_pin.out;
    assign portd_drive_d.oe_n[b] = pd_pin.oe_n;
    assign portd_drive_d.pull_up[b] = pd_pin.pull_up;
    assign portd_drive_d.in_en[b] = pd_pin.in_en;
  end

  always_comb begin
    portc_read_d = portc_pin_i & portc_drive_d.in_en;
    portd_read_d = portd_pin_i & portd_drive_d.in_en;
  end

  // ----------------------------------------------------------------
  // registered drive, frozen while the clock enable is low
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      portc_drive_q <= {pcdo_pkg::RST_PIN_OUT, pcdo_pkg::RST_PIN_OE_N,
                        pcdo_pkg::RST_PIN_PULL_UP, pcdo_pkg::RST_PIN_IN_EN};
      portd_drive_q <= {pcdo_pkg::RST_PIN_OUT, pcdo_pkg::RST_PIN_OE_N,
                        pcdo_pkg::RST_PIN_PULL_UP, pcdo_pkg::RST_PIN_IN_EN};
      portc_read_q <= pcdo_pkg::RST_PIN_READ;
      portd_read_q <= pcdo_pkg::RST_PIN_READ;
    end else if (clk_en_i) begin
      portc_drive_q <= portc_drive_d;
      portd_drive_q <= portd_drive_d;
      portc_read_q <= portc_read_d;
      portd_read_q <= portd_read_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the clock pin skips the flops so it runs through reset and is not delayed a cycle
  always_comb begin
    portc_drive_o = portc_drive_q;
    portd_drive_o = portd_drive_q;
    if (clock_output_fuse_i) begin
      portd_drive_o.out[pcdo_pkg::PD_CLOCK_OUT_BIT] = divided_clock_i; // R13 R14
      portd_drive_o.oe_n[pcdo_pkg::PD_CLOCK_OUT_BIT] = 1'b0; // R13 R14
    end
  end

  assign portc_read_o = portc_read_q;
  assign portd_read_o = portd_read_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_cmpb_value_only: assert property ( // R01
    (clk_en_i && timer1_cmpb_out_enable_i && !stage1_out0_enable_i) |=>
      (portc_drive_q.out[1] == $past(timer1_cmpb_output_i) &&
       portc_drive_q.oe_n[1] == !$past(portc_regs_i.dir[1])))
    else $error("compare b pin value or direction wrong");

  a_stage_out_force: assert property ( // R02
    (clk_en_i && stage2_out3_enable_i) |=>
      (portc_drive_q.oe_n[3] == 1'b0 && portc_drive_q.out[3] == $past(stage2_out3_value_i)))
    else $error("power stage output not forced on port c bit 3");

  a_dac_pin_input: assert property ( // R03
    (clk_en_i && dac_enable_i) |=> (portc_drive_q.oe_n[7] && !portc_drive_q.in_en[7] &&
                                    portc_read_q[7] == 1'b0))
    else $error("dac pin not released to analog");

  a_rx_force_input: assert property ( // R04
    (clk_en_i && usart_rx_enable_i) |=> portd_drive_q.oe_n[4])
    else $error("receive pin not forced to input");

  a_rx_pull_up: assert property ( // R05
    (clk_en_i && usart_rx_enable_i && !pull_up_disable_i) |=>
      (portd_drive_q.pull_up[4] == $past(portd_regs_i.value[4])))
    else $error("receive pin pull-up does not follow value bit");

  a_sck_slave_input: assert property ( // R06
    (clk_en_i && spi_alt_slave && !usart_rx_enable_i) ##1 (clk_en_i [*2]) |->
      $past(portd_drive_q.oe_n[4]))
    else $error("alternate spi clock not input as slave");

  a_tx_force_out: assert property ( // R07
    (clk_en_i && usart_tx_enable_i) |=>
      (!portd_drive_q.oe_n[3] && portd_drive_q.out[3] == $past(usart_txd_i)))
    else $error("transmit pin not driving transmit data");

  a_cmpa0_value: assert property ( // R08
    (clk_en_i && !usart_tx_enable_i && !spi_alt_slave && timer0_cmpa_out_enable_i) |=>
      (portd_drive_q.out[3] == $past(timer0_cmpa_output_i) &&
       portd_drive_q.oe_n[3] == !$past(portd_regs_i.dir[3])))
    else $error("timer 0 compare a not on port d bit 3");

  a_ss_slave_input: assert property ( // R09
    (clk_en_i && spi_alt_slave && !usart_tx_enable_i) |=> portd_drive_q.oe_n[3])
    else $error("slave select not forced to input");

  a_cmpa1_value: assert property ( // R11
    (clk_en_i && timer1_cmpa_out_enable_i) |=>
      (portd_drive_q.out[2] == $past(timer1_cmpa_output_i)))
    else $error("timer 1 compare a not on port d bit 2");

  a_miso_master_in: assert property ( // R12
    (clk_en_i && spi_alt_master) |=> (portd_drive_q.oe_n[2] &&
      portd_drive_q.pull_up[2] == ($past(portd_regs_i.value[2]) && !$past(pull_up_disable_i))))
    else $error("alternate master-in not input as master");

  a_clock_out_reset: assert property ( // R13
    disable iff (1'b0)
    clock_output_fuse_i |-> (portd_drive_o.out[1] == divided_clock_i &&
                             !portd_drive_o.oe_n[1]))
    else $error("divided clock missing on port d bit 1");

  a_clock_in_reset: assert property ( // R14
    disable iff (1'b0)
    (!rst_n_i && clock_output_fuse_i) |-> !portd_drive_o.oe_n[1])
    else $error("divided clock dropped during reset");

  a_freeze_hold: assert property ( // R16
    !clk_en_i |=> ($stable(portc_drive_q) && $stable(portd_drive_q)))
    else $error("state changed with clock enable low");

  c_tx_active: cover property (clk_en_i && usart_tx_enable_i ##1 !portd_drive_q.oe_n[3]);
  c_spi_slave: cover property (clk_en_i && spi_alt_slave ##1 portd_drive_q.oe_n[3]);
  c_dac_on: cover property (clk_en_i && dac_enable_i ##1 !portc_drive_q.in_en[7]);
  c_clock_reset: cover property (disable iff (1'b0) !rst_n_i && clock_output_fuse_i);

endmodule

`default_nettype wire

/* tb/pcdo_pin_model.sv */
`default_nettype none

module pcdo_pin_model (
  input wire logic clk_sys_i,
  input wire pcdo_pkg::pcdo_port_drive_t drive_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // pad levels
  // ----------------------------------------------------------------
  // an undriven pin without pull-up toggles, so a stale level cannot pass
  logic [7:0] float_q = 8'h55;

  always @(posedge clk_sys_i) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!drive_i.oe_n[i]) begin
        pin_o[i] = drive_i.out[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_val_i[i];
      end else if (drive_i.pull_up[i]) begin
        pin_o[i] = 1'b1;
      end else begin
        pin_o[i] = float_q[i];
      end
    end
  end
endmodule

`default_nettype wire

/* tb/port_cd_alternate_pin_override_tb_top.sv */
`default_nettype none

module port_cd_alternate_pin_override_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys_i = 1'b0;
  logic rst_n_i, clk_en_i, fuse, divclk, pud;
  logic s23e, s23v, s22e, s22v, s10e, s10v, t1be, t1b, t1ae, t1a, t0ae, t0a;
  logic dac, rxe, txe, txd, spe, mst, alt, sck, mosi, miso;
  logic [7:0] ext_c_en, ext_c_val, ext_d_en, ext_d_val, pc_pin, pd_pin, pc_rd, pd_rd;
  pcdo_pkg::pcdo_port_regs_t pc, pd;
  pcdo_pkg::pcdo_port_drive_t pc_drv, pd_drv;
  int fails = 0;
  int checked = 0;

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  pcdo_pin_override u_pcdo_pin_override (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .portc_regs_i(pc), .portd_regs_i(pd), .pull_up_disable_i(pud),
    .portc_pin_i(pc_pin), .portd_pin_i(pd_pin),
    .stage2_out3_enable_i(s23e), .stage2_out3_value_i(s23v),
    .stage2_out2_enable_i(s22e), .stage2_out2_value_i(s22v),
    .stage1_out0_enable_i(s10e), .stage1_out0_value_i(s10v),
    .timer1_cmpb_out_enable_i(t1be), .timer1_cmpb_output_i(t1b),
    .timer1_cmpa_out_enable_i(t1ae), .timer1_cmpa_output_i(t1a),
    .timer0_cmpa_out_enable_i(t0ae), .timer0_cmpa_output_i(t0a),
    .dac_enable_i(dac), .ext_int3_enable_i(1'b0), .usart_rx_enable_i(rxe),
    .usart_tx_enable_i(txe), .usart_txd_i(txd), .spi_enable_i(spe), .spi_master_i(mst),
    .spi_alt_pins_i(alt), .spi_sck_out_i(sck), .spi_mosi_out_i(mosi),
    .spi_miso_out_i(miso), .clock_output_fuse_i(fuse), .divided_clock_i(divclk),
    .portc_drive_o(pc_drv), .portd_drive_o(pd_drv), .portc_read_o(pc_rd), .portd_read_o(pd_rd)
  );

  pcdo_pin_model u_pcdo_pin_model_c (
    .clk_sys_i(clk_sys_i), .drive_i(pc_drv), .ext_en_i(ext_c_en), .ext_val_i(ext_c_val),
    .pin_o(pc_pin)
  );

  pcdo_pin_model u_pcdo_pin_model_d (
    .clk_sys_i(clk_sys_i), .drive_i(pd_drv), .ext_en_i(ext_d_en), .ext_val_i(ext_d_val),
    .pin_o(pd_pin)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic settle;
    @(posedge clk_sys_i);
    #2;
  endtask

  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(400 * 25);
    fails++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {s23e, s23v, s22e, s22v, s10e, s10v, t1be, t1b, t1ae, t1a, t0ae, t0a} = '0;
    {dac, rxe, txe, txd, spe, mst, alt, sck, mosi, miso, pud} = '0;
    {ext_c_en, ext_c_val, ext_d_en, ext_d_val} = '0;
    pc = '0;
    pd = '0; // comparator pins stay plain inputs with the pull-up off
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    fuse = 1'b1;
    divclk = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #2;
    chk(pc_drv === 32'h00ff00ff, 1'b1);
    chk(pd_drv === 32'h02fd00ff, 1'b1);
    chk({pc_rd, pd_rd} === 16'h0000, 1'b1);
    @(negedge clk_sys_i);
    divclk = 1'b0;
    #1;
    chk(pd_drv.out[1], 1'b0);
    fuse = 1'b0;
    rst_n_i = 1'b1;
    settle();
    chk(pd_drv.oe_n[1], 1'b1);
    @(negedge clk_sys_i);
    pd.value[1] = 1'b0;
    fuse = 1'b1;
    divclk = 1'b1;
    settle();
    chk(pd_drv.out[1], 1'b1);
    chk(pd_drv.oe_n[1], 1'b0);
    @(negedge clk_sys_i);
    fuse = 1'b0;
    {s23e, s22e, s10e} = 3'h7;
    for (int v = 0; v < 2; v++) begin
      @(negedge clk_sys_i);
      {s23v, s22v, s10v} = {3{v[0]}};
      settle();
      chk(pc_drv.oe_n[3:0] === 4'h2, 1'b1);
      chk(pc_drv.out[3:0] === {v[0], v[0], 1'b0, v[0]}, 1'b1);
    end
    @(negedge clk_sys_i);
    {s23e, s22e, s10e} = 3'h0;
    t1be = 1'b1;
    t1b = 1'b1;
    settle();
    chk(pc_drv.oe_n[3:0] === 4'hf, 1'b1);
    chk(pc_drv.out[1], 1'b1);
    chk(pc_drv.oe_n[1], 1'b1);
    @(negedge clk_sys_i);
    pc.dir[1] = 1'b1;
    pc.dir[7] = 1'b1;
    pc.value[7] = 1'b1;
    dac = 1'b1;
    settle();
    chk(pc_drv.oe_n[1], 1'b0);
    chk(pc_drv.oe_n[7], 1'b1);
    chk(pc_drv.in_en[7], 1'b0);
    settle();
    chk(pc_rd[7], 1'b0);
    @(negedge clk_sys_i);
    dac = 1'b0;
    settle();
    settle();
    chk(pc_rd[7], 1'b1);
    @(negedge clk_sys_i);
    pd.dir[4] = 1'b1;
    pd.value[4] = 1'b1;
    rxe = 1'b1;
    txe = 1'b1;
    {t0ae, t0a} = 2'b11;
    settle();
    chk(pd_drv.oe_n[4], 1'b1);
    chk(pd_drv.pull_up[4], 1'b1);
    chk(pd_drv.oe_n[3], 1'b0);
    chk(pd_drv.out[3], 1'b0);
    @(negedge clk_sys_i);
    pud = 1'b1;
    txd = 1'b1;
    settle();
    chk(pd_drv.pull_up[4], 1'b0);
    chk(pd_drv.out[3], 1'b1);
    @(negedge clk_sys_i);
    {rxe, txe, pud} = 3'b000;
    {t1ae, t1a} = 2'b11;
    pd.dir[2] = 1'b1;
    settle();
    chk(pd_drv.oe_n[4], 1'b0);
    chk(pd_drv.oe_n[3], 1'b1);
    chk({pd_drv.oe_n[2], pd_drv.out[2]} === 2'b01, 1'b1);
    @(negedge clk_sys_i);
    pd.dir[3] = 1'b1;
    pd.dir[2] = 1'b0;
    settle();
    chk({pd_drv.oe_n[3], pd_drv.out[3]} === 2'b01, 1'b1);
    chk(pd_drv.oe_n[2], 1'b1);
    @(negedge clk_sys_i);
    {t0ae, t1ae, spe, alt, miso} = 5'h1f;
    pd.dir[4:2] = 3'h7;
    pd.value[4:2] = 3'h7;
    ext_d_en[3] = 1'b1; // outside master selects this slave
    settle();
    chk(pd_drv.oe_n[4], 1'b1);
    chk(pd_drv.oe_n[3], 1'b1);
    chk(pd_drv.pull_up[4:3] === 2'b11, 1'b1);
    chk({pd_drv.oe_n[2], pd_drv.out[2]} === 2'b01, 1'b1);
    settle();
    chk(pd_rd[3], 1'b0);
    @(negedge clk_sys_i);
    ext_d_en[3] = 1'b0;
    {mst, sck, mosi} = 3'b110;
    settle();
    chk(pd_drv.oe_n[4], 1'b0);
    chk({pd_drv.oe_n[3], pd_drv.out[3]} === 2'b01, 1'b1);
    chk({pd_drv.oe_n[2], pd_drv.pull_up[2]} === 2'b11, 1'b1);
    @(negedge clk_sys_i);
    t0ae = 1'b0;
    settle();
    chk({pd_drv.oe_n[3], pd_drv.out[3]} === 2'b00, 1'b1);
    @(negedge clk_sys_i);
    clk_en_i = 1'b0;
    spe = 1'b0;
    settle();
    chk(pd_drv.oe_n[2], 1'b1);
    settle();
    chk(pd_drv.oe_n[2], 1'b1);
    @(negedge clk_sys_i);
    clk_en_i = 1'b1;
    settle();
    chk(pd_drv.oe_n[2], 1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
